// ---- common/smac_pkg.sv ----
// How it works
// [RL1] Operands and results are signed two's complement
// [RL2] Plain operand write recomputes product only
// [RL3] Accumulate operand write adds product into accumulator
// [RL4] Both X addresses load one shared operand
// [RL5] Writing either clear address zeroes accumulator
// [RL6] Results readable next access, no busy
// [RL7] Software writes plain first, accumulate second
// [RL8] Widths: 8-bit operands, 16 product, 32 accumulator
// [RL9] EAh reads product high, EBh low
// [RL10] ECh acc byte1/acc X; EDh byte0/acc Y
// [RL11] EEh byte3, EFh byte2; writes clear
// [RL12] E8h, E9h are write-only operands
// [RL13] Decoded on internal bus, bank 0
// [RL14] Sign-extended product added, wraps silently
// [RL15] Operands hold until overwritten
package smac_pkg;

    // ------------------------------------------------------------
    // Register offsets (bank 0)
    // ------------------------------------------------------------
    localparam logic [7:0] SMAC_PRODUCT_OPERAND_X = 8'hE8;
    localparam logic [7:0] SMAC_PRODUCT_OPERAND_Y = 8'hE9;
    localparam logic [7:0] SMAC_PRODUCT_HIGH_BYTE = 8'hEA;
    localparam logic [7:0] SMAC_PRODUCT_LOW_BYTE  = 8'hEB;
    localparam logic [7:0] SMAC_ACC_BYTE1_ACC_X   = 8'hEC;
    localparam logic [7:0] SMAC_ACC_BYTE0_ACC_Y   = 8'hED;
    localparam logic [7:0] SMAC_ACC_BYTE3_CLEAR_A = 8'hEE;
    localparam logic [7:0] SMAC_ACC_BYTE2_CLEAR_B = 8'hEF;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          SMAC_OPERAND_W   = 8;
    localparam int          SMAC_PRODUCT_W   = 16;
    localparam int          SMAC_ACC_W       = 32;
    localparam logic [7:0]  SMAC_OPERAND_RST = 8'h00;
    localparam logic [15:0] SMAC_PRODUCT_RST = 16'h0000;
    localparam logic [31:0] SMAC_ACC_RST     = 32'h00000000;
    localparam logic [7:0]  SMAC_UNMAPPED_RD = 8'h00;

endpackage

// ---- tb/smac_cpu_model.sv ----
`timescale 1ns/1ps
module smac_cpu_model
(
    input  wire logic       sys_clk,
    output logic            bank_sel,
    output logic [7:0]      addr,
    output logic [7:0]      wdata,
    output logic            wr_en,
    output logic            rd_en,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid
);
    initial
    begin
        bank_sel = 1'b0;
        addr     = 8'h00;
        wdata    = 8'h00;
        wr_en    = 1'b0;
        rd_en    = 1'b0;
    end

    // --------------------------------------------------------
    // Bus cycles, one strobe cycle each
    // --------------------------------------------------------
    task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bank_sel <= b;
        addr     <= a;
        wdata    <= d;
        wr_en    <= 1'b1;
        @(posedge sys_clk);
        wr_en    <= 1'b0;
        bank_sel <= 1'b0;
        // Released bus shows inverted values so a stale capture is caught
        addr     <= ~a;
        wdata    <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        addr  <= ~a;
        #1;
        d = rdata;
        v = rvalid;
    endtask
endmodule

// ---- tb/smac_top_tb.sv ----
`timescale 1ns/1ps
module smac_top_tb;
    logic       sys_clk;
    logic       rstn;
    logic       bank_sel;
    logic       wr_en;
    logic       rd_en;
    logic       rvalid;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    int         mismatches = 0;
    int         total_checks = 0;

    smac_top DUT (.sys_clk(sys_clk), .rstn(rstn), .bank_sel(bank_sel), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rvalid(rvalid));

    smac_cpu_model cpu (.sys_clk(sys_clk), .bank_sel(bank_sel), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rvalid(rvalid));

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // --------------------------------------------------------
    // Checking helpers
    // --------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        cpu.rd(a, d, v);
        check("rvalid", {7'h00, v}, 8'h01);
        check($sformatf("reg %h", a), d, exp);
    endtask

    // Accumulator is read as {EE, EF, EC, ED}
    task automatic racc(input logic [31:0] exp);
        rchk(8'hEE, exp[31:24]);
        rchk(8'hEF, exp[23:16]);
        rchk(8'hEC, exp[15:8]);
        rchk(8'hED, exp[7:0]);
    endtask

    task automatic summarize;
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #200000;
        mismatches++;
        summarize();
    end

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++)
            rchk(8'(8'hE8 + i), 8'h00);
        cpu.wr(1'b0, 8'hE8, 8'hFD);
        cpu.wr(1'b0, 8'hE9, 8'h07);
        rchk(8'hEA, 8'hFF);
        rchk(8'hEB, 8'hEB);
        racc(32'h00000000);
        // Other bank, read-only place and unmapped read must leave no trace
        cpu.wr(1'b1, 8'hE8, 8'h01);
        cpu.wr(1'b0, 8'hEA, 8'h55);
        rchk(8'hEB, 8'hEB);
        rchk(8'h00, 8'h00);
        cpu.wr(1'b0, 8'hE8, 8'h80);
        cpu.wr(1'b0, 8'hE9, 8'h80);
        cpu.wr(1'b0, 8'hED, 8'h80);
        racc(32'h00004000);
        cpu.wr(1'b0, 8'hEC, 8'h7F);
        racc(32'h00000080);
        rchk(8'hEA, 8'hC0);
        cpu.wr(1'b0, 8'hE9, 8'h02);
        rchk(8'hEB, 8'hFE);
        racc(32'h00000080);
        cpu.wr(1'b0, 8'hEE, 8'hA5);
        racc(32'h00000000);
        cpu.wr(1'b0, 8'hE8, 8'h80);
        cpu.wr(1'b0, 8'hED, 8'h7F);
        racc(32'hFFFFC080);
        rchk(8'hE8, 8'h00);
        cpu.wr(1'b0, 8'hEF, 8'h00);
        racc(32'h00000000);
        // Build up state, then reset in mid-run: everything must return to zero
        cpu.wr(1'b0, 8'hEC, 8'h03);
        racc(32'h0000017D);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        rchk(8'hEB, 8'h00);
        racc(32'h00000000);
        cpu.wr(1'b0, 8'hE9, 8'h05);
        rchk(8'hEB, 8'h00);
        summarize();
    end
endmodule

// ---- verilog/smac_multiplier.sv ----
`timescale 1ns/1ps
module smac_multiplier
    import smac_pkg::*;
#(
    parameter int OPW = SMAC_OPERAND_W
)
(
    input  wire logic signed [OPW-1:0]   op_x,
    input  wire logic signed [OPW-1:0]   op_y,
    output logic signed      [2*OPW-1:0] product
);

    // Elaboration-time guard: a one-bit operand has no magnitude bits
    if (OPW < 2)
    begin
        $error("smac_multiplier: operand width too small");
    end

    // Signed operands give a signed two's complement product
    assign product = op_x * op_y; // RL1

endmodule

// ---- verilog/smac_top.sv ----
`timescale 1ns/1ps
module smac_top
    import smac_pkg::*;
#(
    parameter int OPW = SMAC_OPERAND_W
)
(
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic         bank_sel,
    input  wire logic [7:0]   addr,
    input  wire logic [7:0]   wdata,
    input  wire logic         wr_en,
    input  wire logic         rd_en,
    output logic      [7:0]   rdata,
    output logic              rvalid
);

    // Elaboration-time guard: the byte map only fits 8-bit operands
    if (OPW != SMAC_OPERAND_W)
    begin
        $error("smac_top: only 8-bit operands are mapped");
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic bank0_wr;
    logic wr_prod_x;
    logic wr_prod_y;
    logic wr_acc_x;
    logic wr_acc_y;
    logic wr_clear;

    assign bank0_wr  = wr_en && !bank_sel; // RL13
    assign wr_prod_x = bank0_wr && (addr == SMAC_PRODUCT_OPERAND_X); // RL12
    assign wr_prod_y = bank0_wr && (addr == SMAC_PRODUCT_OPERAND_Y); // RL12
    assign wr_acc_x  = bank0_wr && (addr == SMAC_ACC_BYTE1_ACC_X); // RL10
    assign wr_acc_y  = bank0_wr && (addr == SMAC_ACC_BYTE0_ACC_Y); // RL10
    assign wr_clear  = bank0_wr && ((addr == SMAC_ACC_BYTE3_CLEAR_A)
                                 || (addr == SMAC_ACC_BYTE2_CLEAR_B)); // RL11

    // ------------------------------------------------------------
    // Operand registers
    // ------------------------------------------------------------
    logic signed [7:0] opx_r;
    logic signed [7:0] opy_r;
    logic signed [7:0] opx_nxt;
    logic signed [7:0] opy_nxt;

    // One shared X for both paths; untouched operands are kept
    always_comb
    begin
        opx_nxt = opx_r; // RL15
        opy_nxt = opy_r;
        if (wr_prod_x || wr_acc_x)
        begin
            opx_nxt = wdata; // RL4
        end
        if (wr_prod_y || wr_acc_y)
        begin
            opy_nxt = wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            opx_r <= SMAC_OPERAND_RST;
            opy_r <= SMAC_OPERAND_RST;
        end
        else
        begin
            opx_r <= opx_nxt;
            opy_r <= opy_nxt;
        end
    end

    // ------------------------------------------------------------
    // Multiplier on next operand values
    // ------------------------------------------------------------
    // Using the next values lets the write cycle itself commit the
    // result, so the very next read already sees it without a busy flag.
    logic signed [15:0] prod_nxt;

    smac_multiplier #(.OPW(OPW)) u_mult
    (
        .op_x    (opx_nxt),
        .op_y    (opy_nxt),
        .product (prod_nxt)
    );

    // ------------------------------------------------------------
    // Product and accumulator
    // ------------------------------------------------------------
    logic signed [15:0] prod_r;
    logic signed [31:0] acc_r; // RL8
    logic signed [31:0] acc_nxt;
    logic               any_op_wr;

    assign any_op_wr = wr_prod_x || wr_prod_y || wr_acc_x || wr_acc_y;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prod_r <= SMAC_PRODUCT_RST;
        end
        else if (any_op_wr)
        begin
            prod_r <= prod_nxt; // RL2
        end
    end

    // Overflow wraps: no flag, by design
    always_comb
    begin
        acc_nxt = acc_r;
        if (wr_clear)
        begin
            acc_nxt = SMAC_ACC_RST; // RL5
        end
        else if (wr_acc_x || wr_acc_y)
        begin
            acc_nxt = acc_r + {{16{prod_nxt[15]}}, prod_nxt}; // RL3 RL14
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acc_r <= SMAC_ACC_RST;
        end
        else
        begin
            acc_r <= acc_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rdata_nxt;

    always_comb
    begin
        rdata_nxt = SMAC_UNMAPPED_RD;
        if (!bank_sel)
        begin
            case (addr)
                SMAC_PRODUCT_HIGH_BYTE: rdata_nxt = prod_r[15:8]; // RL9
                SMAC_PRODUCT_LOW_BYTE:  rdata_nxt = prod_r[7:0]; // RL9
                SMAC_ACC_BYTE1_ACC_X:   rdata_nxt = acc_r[15:8]; // RL10
                SMAC_ACC_BYTE0_ACC_Y:   rdata_nxt = acc_r[7:0]; // RL10
                SMAC_ACC_BYTE3_CLEAR_A: rdata_nxt = acc_r[31:24]; // RL11
                SMAC_ACC_BYTE2_CLEAR_B: rdata_nxt = acc_r[23:16]; // RL11
                default:                rdata_nxt = SMAC_UNMAPPED_RD;
            endcase
        end
    end

    // Read data is registered; one cycle after rd_en, no wait states
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata  <= SMAC_UNMAPPED_RD;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= rd_en; // RL6
            if (rd_en)
            begin
                rdata <= rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions: operands and product
    // ------------------------------------------------------------
    a_shared_x: assert property (@(posedge sys_clk) disable iff (!rstn) // RL4
        (wr_prod_x || wr_acc_x) |=> (opx_r == $past(wdata)))
        else $error("shared X not loaded");

    a_y_loaded: assert property (@(posedge sys_clk) disable iff (!rstn) // RL12
        (wr_prod_y || wr_acc_y) |=> (opy_r == $past(wdata)))
        else $error("Y operand not loaded");

    a_hold_x: assert property (@(posedge sys_clk) disable iff (!rstn) // RL15
        !(wr_prod_x || wr_acc_x) |=> $stable(opx_r))
        else $error("X operand changed without write");

    a_hold_ops: assert property (@(posedge sys_clk) disable iff (!rstn) // RL15
        !(wr_prod_y || wr_acc_y) |=> $stable(opy_r))
        else $error("Y operand changed without write");

    a_prod_update: assert property (@(posedge sys_clk) disable iff (!rstn) // RL2
        (wr_prod_x || wr_prod_y) |=> (prod_r == $past(prod_nxt)))
        else $error("product not updated after plain write");

    // Operands are widened before the multiply so no tool can truncate to 8 bits
    a_signed_mult: assert property (@(posedge sys_clk) disable iff (!rstn) // RL1
        (wr_prod_x || wr_prod_y) |=>
            (prod_r == (16'(opx_r) * 16'(opy_r))))
        else $error("product not signed");

    a_acc_prod_too: assert property (@(posedge sys_clk) disable iff (!rstn) // RL3
        (wr_acc_x || wr_acc_y) |=>
            (prod_r == (16'(opx_r) * 16'(opy_r))))
        else $error("product not shown after accumulate");

    a_ro_wr_ignored: assert property (@(posedge sys_clk) disable iff (!rstn) // RL9
        bank0_wr && ((addr == SMAC_PRODUCT_HIGH_BYTE) || (addr == SMAC_PRODUCT_LOW_BYTE))
            |=> $stable(prod_r) && $stable(acc_r))
        else $error("write to result byte changed state");

    // ------------------------------------------------------------
    // Assertions: accumulator
    // ------------------------------------------------------------
    a_plain_keeps_acc: assert property (@(posedge sys_clk) disable iff (!rstn) // RL2
        (wr_prod_x || wr_prod_y) && !wr_clear |=> $stable(acc_r))
        else $error("accumulator moved on plain write");

    // Expected sum is rebuilt from the stored operands, not from the adder input
    a_acc_adds: assert property (@(posedge sys_clk) disable iff (!rstn) // RL3
        (wr_acc_x || wr_acc_y) |=>
            (acc_r == $past(acc_r) + (32'(opx_r) * 32'(opy_r))))
        else $error("accumulate did not add product");

    a_clear_zero: assert property (@(posedge sys_clk) disable iff (!rstn) // RL5
        wr_clear |=> (acc_r == SMAC_ACC_RST))
        else $error("accumulator not cleared");

    a_other_bank: assert property (@(posedge sys_clk) disable iff (!rstn) // RL13
        wr_en && bank_sel |=> $stable(opx_r) && $stable(opy_r) && $stable(acc_r))
        else $error("write in other bank changed state");

    // ------------------------------------------------------------
    // Assertions: read path
    // ------------------------------------------------------------
    a_rvalid_pulse: assert property (@(posedge sys_clk) disable iff (!rstn) // RL6
        rd_en |=> rvalid)
        else $error("read not answered next cycle");

    a_rvalid_idle: assert property (@(posedge sys_clk) disable iff (!rstn) // RL6
        !rd_en |=> !rvalid)
        else $error("read valid without read");

    a_rdata_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // RL6
        !rd_en |=> $stable(rdata))
        else $error("read data moved without read");

    // Read data shows the state before the read edge, hence the past values
    a_rd_latency: assert property (@(posedge sys_clk) disable iff (!rstn) // RL6
        rd_en && !bank_sel && (addr == SMAC_PRODUCT_LOW_BYTE)
            |=> rvalid && (rdata == $past(prod_r[7:0])))
        else $error("product low read wrong");

    a_rd_prod_high: assert property (@(posedge sys_clk) disable iff (!rstn) // RL9
        rd_en && !bank_sel && (addr == SMAC_PRODUCT_HIGH_BYTE)
            |=> (rdata == $past(prod_r[15:8])))
        else $error("product high read wrong");

    a_rd_acc_b1: assert property (@(posedge sys_clk) disable iff (!rstn) // RL10
        rd_en && !bank_sel && (addr == SMAC_ACC_BYTE1_ACC_X)
            |=> (rdata == $past(acc_r[15:8])))
        else $error("accumulator byte 1 read wrong");

    a_rd_acc_b0: assert property (@(posedge sys_clk) disable iff (!rstn) // RL10
        rd_en && !bank_sel && (addr == SMAC_ACC_BYTE0_ACC_Y)
            |=> (rdata == $past(acc_r[7:0])))
        else $error("accumulator byte 0 read wrong");

    a_rd_acc_top: assert property (@(posedge sys_clk) disable iff (!rstn) // RL11
        rd_en && !bank_sel && (addr == SMAC_ACC_BYTE3_CLEAR_A)
            |=> (rdata == $past(acc_r[31:24])))
        else $error("accumulator top byte read wrong");

    a_rd_acc_b2: assert property (@(posedge sys_clk) disable iff (!rstn) // RL11
        rd_en && !bank_sel && (addr == SMAC_ACC_BYTE2_CLEAR_B)
            |=> (rdata == $past(acc_r[23:16])))
        else $error("accumulator byte 2 read wrong");

    a_rd_wo_zero: assert property (@(posedge sys_clk) disable iff (!rstn) // RL12
        rd_en && !bank_sel
            && ((addr == SMAC_PRODUCT_OPERAND_X) || (addr == SMAC_PRODUCT_OPERAND_Y))
            |=> (rdata == SMAC_UNMAPPED_RD))
        else $error("write-only operand read not zero");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_plain_mult: cover property (@(posedge sys_clk) disable iff (!rstn)
        wr_prod_x ##[1:4] wr_prod_y);

    c_mac_seq: cover property (@(posedge sys_clk) disable iff (!rstn) // RL7
        wr_prod_x ##[1:4] wr_acc_y ##[1:2] rd_en);

    c_clear: cover property (@(posedge sys_clk) disable iff (!rstn)
        wr_clear ##[1:4] rvalid);

    c_other_bank: cover property (@(posedge sys_clk) disable iff (!rstn)
        wr_en && bank_sel);

    c_restart: cover property (@(posedge sys_clk) disable iff (!rstn)
        $rose(rstn) ##[1:4] rd_en);

endmodule
